// *** rtl/can_bit_timing.sv ***
// bit timing registers, delay compensation and time base counter
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
// What this block does
// - data quantum is prescaler+1 system clocks
// - data segment 2 field n gives n+1 quanta
// - timing writes accepted only in configuration mode
// - edge filter during integration when enabled
// - twelve-bit id uses rrs as lowest bit
// - mode 00 off, 01 manual, 1x automatic
// - automatic: measured delay plus segment 1 plus offset
// - manual: programmed value plus signed offset
// - offset is 7-bit signed system clock count
// - 6-bit value is the manual delay term
// - 32-bit counter advances once per prescale period
// - disabled counter stops and reads zero
// - counter writes load the addressed half and clear prescale count
// - unimplemented bits read zero, ignore writes
// - prescale n gives one step per n+1 clocks
// - nominal segment 1 field n gives n+1 quanta
module can_bit_timing
   import can_timing_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,
   input  wire logic [2:0]        operating_mode_status,
   input  wire logic              nominal_run,
   input  wire logic              data_phase,
   input  wire logic              hard_sync,
   input  wire logic              bus_integrating,
   input  wire logic              can_tx,
   input  wire logic              can_rx,
   input  wire logic              fd_base_frame,
   input  wire logic [10:0]       base_id_in,
   input  wire logic              rrs_bit,
   output logic      [11:0]       base_id,
   output logic                   rx_edge,
   output bit_timing_out_s        nominal_timing,
   output bit_timing_out_s        data_timing,
   output logic      [15:0]       ssp_position,
   output logic                   ssp_enable,
   output logic                   time_base_enable,
   output logic      [31:0]       time_base_counter
);

   core_state_s st;
   core_state_s next_st;

   // register read image; every bit not listed stays zero
   function automatic logic [15:0] reg_read(input logic [3:0] a, input core_state_s s);
      logic [15:0] v;
      v = '0;
      case (a)
         OFS_NOM_PRESC_SEG1: v = {s.nom.presc, s.nom.seg1};
         OFS_NOM_SEG2_SJW:   v = {1'b0, s.nom.seg2, 1'b0, s.nom.resync_jump_width};
         OFS_DAT_PRESC_SEG1: v = {s.dat.presc, 3'h0, s.dat.seg1};
         OFS_DAT_SEG2_SJW:   v = {4'h0, s.dat.seg2, 4'h0, s.dat.resync_jump_width};
         OFS_TDC_CONTROL:
            v = {6'h00, s.tdc.edge_filt_en, s.tdc.twelve_bit_id_en, 6'h00, s.tdc.mode};
         OFS_TDC_OFFS_VALUE:
            v = {1'b0, s.tdc.offset, 2'h0, s.tdc.mode[1] ? s.measured : s.tdc.value};
         OFS_TB_UPPER:       v = s.tb.count[31:16];
         OFS_TB_LOWER:       v = s.tb.count[15:0];
         OFS_TS_CONTROL:     v = {15'h0000, s.tb.enable};
         OFS_TS_PRESCALE:    v = {6'h00, s.tb.prescale};
         default:            v = '0;
      endcase
      return v;
   endfunction

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      return a == ofs;
   endfunction

   logic               cfg_wr;
   logic               tb_wr;
   logic               rx_fall;
   logic               tx_fall;
   logic [13:0]        seg1_clks;
   logic signed [16:0] offs_ext;
   logic signed [16:0] ssp_sum;

   assign cfg_wr    = wr && (operating_mode_status == CONFIG_MODE);
   assign tb_wr     = wr && (hit(addr, OFS_TB_UPPER) || hit(addr, OFS_TB_LOWER));
   assign rx_fall   = st.rx_prev && !can_rx;
   assign tx_fall   = st.tx_prev && !can_tx;
   assign seg1_clks = (14'(st.dat.seg1) + 14'd1) * (14'(st.dat.presc) + 14'd1);
   assign offs_ext  = {{10{st.tdc.offset[6]}}, st.tdc.offset};

   always_comb
   begin
      next_st         = st;
      next_st.rdata   = '0;
      next_st.rx_prev = can_rx;
      next_st.tx_prev = can_tx;
      next_st.rx_edge = 1'b0;
      ssp_sum         = '0;

      if (rd)
         next_st.rdata = reg_read(addr, st);

      // bit timing and delay compensation configuration
      if (cfg_wr)
      begin
         case (addr)
            OFS_NOM_PRESC_SEG1:
            begin
               next_st.nom.presc = wdata[15:8];
               next_st.nom.seg1  = wdata[7:0];
            end
            OFS_NOM_SEG2_SJW:
            begin
               next_st.nom.seg2 = wdata[14:8];
               next_st.nom.resync_jump_width  = wdata[6:0];
            end
            OFS_DAT_PRESC_SEG1:
            begin
               next_st.dat.presc = wdata[15:8];
               next_st.dat.seg1  = wdata[4:0];
            end
            OFS_DAT_SEG2_SJW:
            begin
               next_st.dat.seg2 = wdata[11:8];
               next_st.dat.resync_jump_width  = wdata[3:0];
            end
            OFS_TDC_CONTROL:
            begin
               next_st.tdc.edge_filt_en     = wdata[FILT_EN_BIT];
               next_st.tdc.twelve_bit_id_en = wdata[ID12_EN_BIT];
               next_st.tdc.mode             = wdata[1:0];
            end
            OFS_TDC_OFFS_VALUE:
            begin
               next_st.tdc.offset = wdata[14:8];
               next_st.tdc.value  = wdata[5:0];
            end
            default:
               next_st.tdc = st.tdc;
         endcase
      end

      // falling edges on rx; filtered while integrating if enabled
      if (st.tdc.edge_filt_en && bus_integrating)
      begin
         if (can_rx)
            next_st.filt_cnt = '0;
         else if (nominal_timing.tq_tick && st.filt_cnt != EDGE_FILTER_TQ)
         begin
            next_st.filt_cnt = st.filt_cnt + 2'd1;
            next_st.rx_edge  = (st.filt_cnt + 2'd1 == EDGE_FILTER_TQ);
         end
      end
      else
      begin
         next_st.filt_cnt = '0;
         next_st.rx_edge  = rx_fall;
      end

      // loop delay: tx falling edge to rx falling edge in system clocks
      if (st.tdc.mode[1])
      begin
         if (st.measuring)
         begin
            if (rx_fall)
            begin
               next_st.measured  = st.meas_cnt;
               next_st.measuring = 1'b0;
            end
            else if (st.meas_cnt != DELAY_COMP_VALUE_MAX)
               next_st.meas_cnt = st.meas_cnt + 6'd1;
         end
         else if (tx_fall)
         begin
            next_st.measuring = 1'b1;
            next_st.meas_cnt  = '0;
         end
      end
      else
         next_st.measuring = 1'b0;

      // secondary sample point, clamped at zero
      if (st.tdc.mode[1])
         ssp_sum = 17'(st.measured) + 17'(seg1_clks) + offs_ext;
      else if (st.tdc.mode == TDC_MANUAL)
         ssp_sum = 17'(st.tdc.value) + offs_ext;
      next_st.ssp_enable   = (st.tdc.mode != TDC_DISABLED);
      next_st.ssp_position = ssp_sum[16] ? 16'h0000 : ssp_sum[15:0];

      // timestamp control and prescale
      if (wr && hit(addr, OFS_TS_CONTROL))
         next_st.tb.enable = wdata[TS_EN_BIT];
      if (wr && hit(addr, OFS_TS_PRESCALE))
         next_st.tb.prescale = wdata[9:0];

      // time base counter
      if (st.tb.enable)
      begin
         if (tb_wr)
         begin
            next_st.tb.presc_cnt = '0;
            if (hit(addr, OFS_TB_UPPER))
               next_st.tb.count[31:16] = wdata;
            else
               next_st.tb.count[15:0] = wdata;
         end
         else if (st.tb.presc_cnt == st.tb.prescale)
         begin
            next_st.tb.presc_cnt = '0;
            next_st.tb.count     = st.tb.count + 32'h0000_0001;
         end
         else
            next_st.tb.presc_cnt = st.tb.presc_cnt + 10'h001;
      end
      else
      begin
         // held at zero so it does not toggle
         next_st.tb.presc_cnt = '0;
         next_st.tb.count     = '0;
      end

      // base identifier assembly for fd base format frames
      if (st.tdc.twelve_bit_id_en && fd_base_frame)
         next_st.base_id = {base_id_in, rrs_bit};
      else
         next_st.base_id = {1'b0, base_id_in};
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st           <= '0;
         st.rx_prev   <= 1'b1;
         st.tx_prev   <= 1'b1;
         st.nom       <= '{RST_NOM_PRESC, RST_NOM_SEG1, RST_NOM_SEG2, RST_NOM_SJW};
         st.dat       <= '{RST_DAT_PRESC, RST_DAT_SEG1, RST_DAT_SEG2, RST_DAT_SJW};
         st.tdc.mode  <= RST_TDC_MODE;
         st.tdc.offset <= RST_TDC_OFFS;
         st.tdc.value <= RST_TDC_VALUE;
      end
      else if (ce)
         st <= next_st;
   end

   bit_time_gen #(
      .PRESC_W (8),
      .SEG1_W  (8),
      .SEG2_W  (7),
      .SJW_W   (7)
   ) nominal_gen (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .run       (nominal_run && !data_phase),
      .hard_sync (hard_sync),
      .rx_edge   (st.rx_edge),
      .presc     (st.nom.presc),
      .seg1      (st.nom.seg1),
      .seg2      (st.nom.seg2),
      .resync_jump_width       (st.nom.resync_jump_width),
      .timing    (nominal_timing)
   );

   bit_time_gen #(
      .PRESC_W (8),
      .SEG1_W  (5),
      .SEG2_W  (4),
      .SJW_W   (4)
   ) data_gen (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .run       (data_phase),
      .hard_sync (1'b0),
      .rx_edge   (st.rx_edge),
      .presc     (st.dat.presc),
      .seg1      (st.dat.seg1),
      .seg2      (st.dat.seg2),
      .resync_jump_width       (st.dat.resync_jump_width),
      .timing    (data_timing)
   );

   assign rdata             = st.rdata;
   assign base_id           = st.base_id;
   assign rx_edge           = st.rx_edge;
   assign ssp_position      = st.ssp_position;
   assign ssp_enable        = st.ssp_enable;
   assign time_base_enable  = st.tb.enable;
   assign time_base_counter = st.tb.count;

endmodule

// *** rtl/can_timing_pkg.sv ***
// constants, register map and carrier types of the can fd bit timing block
package can_timing_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   localparam logic [3:0] OFS_NOM_PRESC_SEG1 = 4'h0;
   localparam logic [3:0] OFS_NOM_SEG2_SJW   = 4'h1;
   localparam logic [3:0] OFS_DAT_PRESC_SEG1 = 4'h2;
   localparam logic [3:0] OFS_DAT_SEG2_SJW   = 4'h3;
   localparam logic [3:0] OFS_TDC_CONTROL    = 4'h4;
   localparam logic [3:0] OFS_TDC_OFFS_VALUE = 4'h5;
   localparam logic [3:0] OFS_TB_UPPER       = 4'h6;
   localparam logic [3:0] OFS_TB_LOWER       = 4'h7;
   localparam logic [3:0] OFS_TS_CONTROL     = 4'h8;
   localparam logic [3:0] OFS_TS_PRESCALE    = 4'h9;

   localparam logic [7:0] RST_NOM_PRESC = 8'h00;
   localparam logic [7:0] RST_NOM_SEG1  = 8'h3e;
   localparam logic [6:0] RST_NOM_SEG2  = 7'h0f;
   localparam logic [6:0] RST_NOM_SJW   = 7'h0f;
   localparam logic [7:0] RST_DAT_PRESC = 8'h00;
   localparam logic [4:0] RST_DAT_SEG1  = 5'h0e;
   localparam logic [3:0] RST_DAT_SEG2  = 4'h3;
   localparam logic [3:0] RST_DAT_SJW   = 4'h3;
   localparam logic [1:0] RST_TDC_MODE  = 2'h2;
   localparam logic [6:0] RST_TDC_OFFS  = 7'h10;
   localparam logic [5:0] RST_TDC_VALUE = 6'h00;

   localparam logic [2:0] CONFIG_MODE    = 3'h4;
   localparam logic [1:0] TDC_DISABLED   = 2'h0;
   localparam logic [1:0] TDC_MANUAL     = 2'h1;
   localparam logic [5:0] DELAY_COMP_VALUE_MAX       = 6'h3f;
   localparam logic [1:0] EDGE_FILTER_TQ = 2'h2;

   // field positions inside the 16-bit registers
   localparam int HI_LSB      = 8;
   localparam int TS_EN_BIT   = 0;
   localparam int FILT_EN_BIT = 9;
   localparam int ID12_EN_BIT = 8;

   typedef enum {SYNC_SEG, PHASE_SEG1, PHASE_SEG2} bit_phase_e;

   typedef struct packed {
      logic [7:0] presc;
      logic [7:0] seg1;
      logic [6:0] seg2;
      logic [6:0] resync_jump_width;
   } nominal_cfg_s;

   typedef struct packed {
      logic [7:0] presc;
      logic [4:0] seg1;
      logic [3:0] seg2;
      logic [3:0] resync_jump_width;
   } data_cfg_s;

   typedef struct packed {
      logic       edge_filt_en;
      logic       twelve_bit_id_en;
      logic [1:0] mode;
      logic [6:0] offset;
      logic [5:0] value;
   } tdc_cfg_s;

   typedef struct packed {
      logic        enable;
      logic [9:0]  prescale;
      logic [9:0]  presc_cnt;
      logic [31:0] count;
   } time_base_s;

   typedef struct packed {
      logic tq_tick;
      logic sample_point;
      logic bit_start;
   } bit_timing_out_s;

   typedef struct packed {
      nominal_cfg_s nom;
      data_cfg_s    dat;
      tdc_cfg_s     tdc;
      time_base_s   tb;
      logic         rx_prev;
      logic         tx_prev;
      logic [1:0]   filt_cnt;
      logic         rx_edge;
      logic         measuring;
      logic [5:0]   meas_cnt;
      logic [5:0]   measured;
      logic [15:0]  ssp_position;
      logic         ssp_enable;
      logic [15:0]  rdata;
      logic [11:0]  base_id;
   } core_state_s;

endpackage

// *** rtl/bit_time_gen.sv ***
// quantum prescaler and bit segment sequencer for one phase
`timescale 1ns/10ps
module bit_time_gen
   import can_timing_pkg::*;
#(
   parameter int PRESC_W = 8,
   parameter int SEG1_W  = 8,
   parameter int SEG2_W  = 7,
   parameter int SJW_W   = 7
)
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               ce,
   input  wire logic               run,
   input  wire logic               hard_sync,
   input  wire logic               rx_edge,
   input  wire logic [PRESC_W-1:0] presc,
   input  wire logic [SEG1_W-1:0]  seg1,
   input  wire logic [SEG2_W-1:0]  seg2,
   input  wire logic [SJW_W-1:0]   resync_jump_width,
   output bit_timing_out_s         timing
);

   typedef struct packed {
      logic [PRESC_W-1:0] presc_cnt;
      bit_phase_e         phase;
      logic [8:0]         seg_cnt;
      logic [8:0]         lim;
      bit_timing_out_s    out;
   } gen_state_s;

   gen_state_s st;
   gen_state_s next_st;
   logic [8:0] jump;
   logic [8:0] err;

   assign jump = 9'(resync_jump_width) + 9'd1;
   assign err  = st.seg_cnt + 9'd1;

   always_comb
   begin
      next_st     = st;
      next_st.out = '0;
      if (!run)
      begin
         next_st.presc_cnt = '0;
         next_st.phase     = SYNC_SEG;
         next_st.seg_cnt   = '0;
      end
      else if (hard_sync)
      begin
         // the edge itself is the sync quantum
         next_st.presc_cnt     = '0;
         next_st.phase         = PHASE_SEG1;
         next_st.seg_cnt       = '0;
         next_st.lim           = 9'(seg1);
         next_st.out.bit_start = 1'b1;
      end
      else
      begin
         if (rx_edge && st.phase == PHASE_SEG1)
            next_st.lim = 9'(seg1) + ((err < jump) ? err : jump);
         else if (rx_edge && st.phase == PHASE_SEG2)
            next_st.lim = (st.lim < st.seg_cnt + jump) ? st.seg_cnt : st.lim - jump;
         if (st.presc_cnt == presc)
         begin
            next_st.presc_cnt   = '0;
            next_st.out.tq_tick = 1'b1;
            case (st.phase)
               SYNC_SEG:
               begin
                  next_st.phase   = PHASE_SEG1;
                  next_st.seg_cnt = '0;
                  next_st.lim     = 9'(seg1);
               end
               PHASE_SEG1:
               begin
                  if (st.seg_cnt >= next_st.lim)
                  begin
                     next_st.phase            = PHASE_SEG2;
                     next_st.seg_cnt          = '0;
                     next_st.lim              = 9'(seg2);
                     next_st.out.sample_point = 1'b1;
                  end
                  else
                     next_st.seg_cnt = st.seg_cnt + 9'd1;
               end
               PHASE_SEG2:
               begin
                  if (st.seg_cnt >= next_st.lim)
                  begin
                     next_st.phase         = SYNC_SEG;
                     next_st.seg_cnt       = '0;
                     next_st.out.bit_start = 1'b1;
                  end
                  else
                     next_st.seg_cnt = st.seg_cnt + 9'd1;
               end
               default:
                  next_st.phase = SYNC_SEG;
            endcase
         end
         else
            next_st.presc_cnt = st.presc_cnt + PRESC_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st       <= '0;
         st.phase <= SYNC_SEG;
      end
      else if (ce)
         st <= next_st;
   end

   assign timing = st.out;

endmodule

// *** verif/can_bus_model.sv ***
// bus and transceiver model: echoes the transmit pin after a loop delay
`timescale 1ns/10ps
module can_bus_model
#(
   parameter int DELAY = 5
)
(
   input  wire logic clk,
   input  wire logic can_tx,
   output logic      can_rx
);
   // recessive idle level, the transceiver pulls the line high
   logic [DELAY-1:0] line = '1;
   always @(posedge clk)
   begin
      line <= {line[DELAY-2:0], can_tx};
   end
   assign can_rx = line[DELAY-1];
endmodule

// *** verif/can_bit_timing_assertions.sv ***
// port assertions of the bit timing block
`timescale 1ns/10ps
module can_bit_timing_checker
   import can_timing_pkg::*;
(
   input wire logic              clk,
   input wire logic              srst,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [2:0]        operating_mode_status,
   input wire logic              fd_base_frame,
   input wire logic [10:0]       base_id_in,
   input wire logic              can_rx,
   input wire logic [11:0]       base_id,
   input wire logic              rx_edge,
   input wire bit_timing_out_s   nominal_timing,
   input wire bit_timing_out_s   data_timing,
   input wire logic              ssp_enable,
   input wire logic              time_base_enable,
   input wire logic [31:0]       time_base_counter
);
   logic rd_take;
   logic tb_wr;
   logic en_bit;
   assign rd_take = rd && ce;
   assign tb_wr = wr && (addr == OFS_TB_UPPER || addr == OFS_TB_LOWER);
   assign en_bit = wdata[TS_EN_BIT];
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_cfg_write;
      wr && ce && addr == OFS_TDC_CONTROL && operating_mode_status == CONFIG_MODE ##1 1'b1;
   endsequence
   property p_rdata_idle; !$past(rd_take) |-> rdata == '0; endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not idle");
   property p_unmapped; rd_take && addr > OFS_TS_PRESCALE |=> rdata == '0; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_tb_clear; ce && !time_base_enable |=> time_base_counter == '0; endproperty
   a_tb_clear: assert property (p_tb_clear)
      else $error("disabled counter not zero");
   property p_tb_step;
      time_base_enable && !tb_wr |=> time_base_counter - $past(time_base_counter) <= 32'h1;
   endproperty
   a_tb_step: assert property (p_tb_step)
      else $error("counter step wrong");
   property p_tb_load;
      wr && ce && addr == OFS_TB_UPPER && time_base_enable
         |=> time_base_counter[31:16] == $past(wdata);
   endproperty
   a_tb_load: assert property (p_tb_load)
      else $error("upper half not loaded");
   property p_tb_enable;
      wr && ce && addr == OFS_TS_CONTROL |=> time_base_enable == $past(en_bit);
   endproperty
   a_tb_enable: assert property (p_tb_enable)
      else $error("counter enable not taken");
   property p_base_id; ce && !fd_base_frame |=> base_id == {1'b0, $past(base_id_in)}; endproperty
   a_base_id: assert property (p_base_id)
      else $error("classic identifier wrong");
   property p_rx_edge; rx_edge |-> !$past(can_rx) ##1 !rx_edge; endproperty
   a_rx_edge: assert property (p_rx_edge)
      else $error("edge pulse wrong");
   property p_no_overlap;
      !(nominal_timing.sample_point && nominal_timing.bit_start)
         && !(data_timing.sample_point && data_timing.bit_start);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("sample point at bit start");
   property p_tdc_enable;
      s_cfg_write |=> ssp_enable == (($past(wdata, 2) & 16'h0003) != 16'h0000);
   endproperty
   a_tdc_enable: assert property (p_tdc_enable)
      else $error("compensation enable wrong");
endmodule

bind can_bit_timing can_bit_timing_checker can_bit_timing_checker_i (
   .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .operating_mode_status(operating_mode_status),
   .fd_base_frame(fd_base_frame), .base_id_in(base_id_in), .can_rx(can_rx),
   .base_id(base_id), .rx_edge(rx_edge), .nominal_timing(nominal_timing),
   .data_timing(data_timing), .ssp_enable(ssp_enable),
   .time_base_enable(time_base_enable), .time_base_counter(time_base_counter));

// *** verif/test_can_fd_bit_timing_and_time_base.sv ***
// register level tests of the bit timing block and its time base
`timescale 1ns/10ps
module test_can_fd_bit_timing_and_time_base
   import can_timing_pkg::*;
;
   localparam int DLY = 5;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, hard_sync = 1'b0;
   logic nominal_run = 1'b0, data_phase = 1'b0, bus_integrating = 1'b0, can_tx = 1'b1;
   logic fd_base_frame = 1'b0, rrs_bit = 1'b0, can_rx, rx_edge, ssp_enable, time_base_enable;
   logic [3:0] addr = '0;
   logic [15:0] wdata = '0, rdata, d, ssp_position;
   logic [2:0] operating_mode_status = 3'h0;
   logic [10:0] base_id_in = '0;
   logic [11:0] base_id;
   logic [31:0] time_base_counter;
   bit_timing_out_s nominal_timing, data_timing, t;
   logic [15:0] rst_val [12] = '{16'h003e, 16'h0f0f, 16'h000e, 16'h0303, 16'h0002,
      16'h1000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [15:0] ones_val [6] = '{16'hffff, 16'h7f7f, 16'hff1f, 16'h0f0f, 16'h0301, 16'h7f3f};
   int n_errors = 0, n_compared = 0, cycles = 0, len, seg2, ticks;

   can_bit_timing can_bit_timing_i (
      .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .operating_mode_status(operating_mode_status),
      .nominal_run(nominal_run), .data_phase(data_phase), .hard_sync(hard_sync),
      .bus_integrating(bus_integrating), .can_tx(can_tx), .can_rx(can_rx),
      .fd_base_frame(fd_base_frame), .base_id_in(base_id_in), .rrs_bit(rrs_bit),
      .base_id(base_id), .rx_edge(rx_edge), .nominal_timing(nominal_timing),
      .data_timing(data_timing), .ssp_position(ssp_position), .ssp_enable(ssp_enable),
      .time_base_enable(time_base_enable), .time_base_counter(time_base_counter));
   can_bus_model #(.DELAY(DLY)) can_bus_model_i (.clk(clk), .can_tx(can_tx), .can_rx(can_rx));

   initial forever #20 clk = ~clk;

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         n_errors++;
         $display("Error at %0t: timeout", $time);
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      rd_reg(a);
      chk(d, e);
   endtask

   // one whole bit between two bit starts of the selected phase
   task automatic bit_len(input logic dat);
      len = 0;
      seg2 = 0;
      ticks = 0;
      t = '0;
      while (t.bit_start !== 1'b1 && len < 600)
      begin
         tick(1);
         t = dat ? data_timing : nominal_timing;
         len++;
      end
      {len, t} = '0;
      while (t.bit_start !== 1'b1 && len < 600)
      begin
         tick(1);
         t = dat ? data_timing : nominal_timing;
         len++;
         ticks += t.tq_tick;
         seg2 = (t.sample_point === 1'b1) ? 0 : seg2 + 1;
      end
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      foreach (rst_val[i]) rd_chk(4'(i), rst_val[i]);
      $display("reset values done");
      @(posedge clk) operating_mode_status <= CONFIG_MODE;
      for (int i = 0; i < 6; i++) wr_reg(4'(i), i == 4 ? 16'hfffd : 16'hffff);
      foreach (ones_val[i]) rd_chk(4'(i), ones_val[i]);
      @(posedge clk) operating_mode_status <= 3'h0;
      for (int i = 0; i < 6; i++) wr_reg(4'(i), 16'h0000);
      foreach (ones_val[i]) rd_chk(4'(i), ones_val[i]);
      $display("configuration access done");
      @(posedge clk) operating_mode_status <= CONFIG_MODE;
      chk({ssp_enable, ssp_position}, 32'h1003e);
      wr_reg(4'h5, 16'h400a);
      tick(3);
      chk(ssp_position, 32'd0);
      wr_reg(4'h5, 16'h0305);
      tick(3);
      chk(ssp_position, 32'd8);
      wr_reg(4'h4, 16'h0000);
      tick(3);
      chk({ssp_enable, ssp_position}, 32'd0);
      wr_reg(4'h2, 16'h0102);
      wr_reg(4'h5, 16'h7e00);
      for (int m = 2; m < 4; m++)
      begin
         wr_reg(4'h4, 16'(m));
         @(posedge clk) can_tx <= 1'b0;
         repeat (DLY + 4) @(posedge clk);
         can_tx <= 1'b1;
         tick(DLY + 4);
         rd_reg(4'h5);
         chk(d[5:0] inside {DLY - 1, DLY, DLY + 1}, 1'b1);
         chk({ssp_enable, ssp_position}, 32'h10004 + d[5:0]);
      end
      wr_reg(4'h4, 16'h0101);
      @(posedge clk);
      fd_base_frame <= 1'b1;
      base_id_in <= 11'h5a5;
      rrs_bit <= 1'b1;
      tick(2);
      chk(base_id, 12'hb4b);
      @(posedge clk) fd_base_frame <= 1'b0;
      tick(2);
      chk(base_id, 12'h5a5);
      wr_reg(4'h4, 16'h0001);
      @(posedge clk) fd_base_frame <= 1'b1;
      tick(2);
      chk(base_id, 12'h5a5);
      $display("compensation and identifier done");
      wr_reg(4'h0, 16'h0003);
      wr_reg(4'h1, 16'h0202);
      @(posedge clk);
      nominal_run <= 1'b1;
      bus_integrating <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         wr_reg(4'h4, k == 0 ? 16'h0001 : 16'h0201);
         @(posedge clk) can_tx <= 1'b0;
         len = 0;
         for (int c = 0; c < 16; c++)
         begin
            @(posedge clk);
            if (c == (k == 2 ? 5 : 0)) can_tx <= 1'b1;
            #1 len += rx_edge;
         end
         chk(len, k != 1);
      end
      @(posedge clk) bus_integrating <= 1'b0;
      bit_len(1'b0);
      chk(len, 32'd8);
      chk(seg2, 32'd3);
      wr_reg(4'h3, 16'h0100);
      @(posedge clk) data_phase <= 1'b1;
      bit_len(1'b1);
      chk(len, 32'd12);
      chk(seg2, 32'd4);
      chk(ticks, 32'd6);
      @(posedge clk) data_phase <= 1'b0;
      @(posedge clk) hard_sync <= 1'b1;
      @(posedge clk) hard_sync <= 1'b0;
      #1 chk(nominal_timing.bit_start, 1'b1);
      $display("bit timing done");
      for (int p = 0; p < 3; p += 2)
      begin
         wr_reg(4'h9, 16'(p));
         wr_reg(4'h8, 16'h0001);
         wr_reg(4'h6, 16'hffff);
         wr_reg(4'h7, 16'hfffe);
         for (int k = 1; k < 10; k++)
         begin
            tick(1);
            chk(time_base_counter, 32'hfffffffe + 32'(k / (p + 1)));
         end
      end
      rd_chk(4'h6, 16'h0000);
      chk(time_base_enable, 1'b1);
      @(posedge clk) ce <= 1'b0;
      tick(1);
      d = time_base_counter[15:0];
      tick(4);
      chk(time_base_counter, {16'h0000, d});
      @(posedge clk) ce <= 1'b1;
      wr_reg(4'h8, 16'h0000);
      tick(2);
      chk(time_base_counter, 32'h0);
      chk(time_base_enable, 1'b0);
      wr_reg(4'h7, 16'h1234);
      rd_chk(4'h7, 16'h0000);
      $display("time base done");
      wrap_up();
   end
endmodule
